/* hcl_loader.sv */
// hub identity and configuration loader reading a serial memory image
// Function
// - default signature: take only three identifiers
// - configured signature: read thirteen-byte image
// - identifiers low byte first, vendor first
// - read command with two address bytes
// - byte 7 gives two overcurrent filter times
// - byte 8 high nibble: usable ports, count
// - byte 8 low nibble: removable port bits
// - byte 9 is upstream power in 2 mA
// - byte 10 is controller current in mA
// - byte 11 is power-good time in 2 ms
// - bit 7 lets zero descriptor type through
// - bit 6 is ignored
// - bit 5 forces full speed only
// - bit 4 turns indicators off, clears b7
// - port power control mask is all ones
// - bit 2 selects ganged power and overcurrent
// - bit 1 selects single translator mode
// - bit 0 suppresses end-of-frame EOP
`timescale 1ns/1ns

module hcl_loader
	import hcl_pkg::*;
#(
	parameter logic [15:0] DEF_VENDOR_ID  = 16'h0001, // arbitrary value
	parameter logic [15:0] DEF_PRODUCT_ID = 16'h0002, // arbitrary value
	parameter logic [15:0] DEF_RELEASE_ID = 16'h0003  // arbitrary value
) (
	// clock and reset
	input  wire  logic        clk,
	input  wire  logic        rst_b,
	// serial memory pins
	output logic              mem_sck,
	output logic              mem_cs_b,
	output logic              mem_mosi,
	input  wire  logic        mem_miso,
	// register port
	input  wire  logic [3:0]  reg_addr,
	input  wire  logic [31:0] reg_wdata,
	input  wire  logic        reg_wr,
	input  wire  logic        reg_rd,
	output logic [31:0]       reg_rdata,
	// descriptor type check from request handling
	input  wire  logic [7:0]  hub_desc_type,
	output logic              hub_desc_stall,
	// loaded configuration
	output logic              config_valid,
	output logic [15:0]       vendor_id,
	output logic [15:0]       product_id,
	output logic [15:0]       device_release_id,
	output logic [3:0]        enabled_port_oc_filter_ms,
	output logic [3:0]        disabled_port_oc_filter_ms,
	output logic [3:0]        usable_port_mask,
	output logic [2:0]        port_count,
	output logic [3:0]        detachable_port_mask,
	output logic [7:0]        upstream_current_budget,
	output logic [7:0]        controller_current_need,
	output logic [7:0]        port_power_settle_time,
	output logic [15:0]       hub_characteristics,
	output logic [7:0]        port_power_ctrl_mask,
	output logic              accept_zero_desc_type,
	output logic              limit_to_12mbit,
	output logic              indicator_leds_off,
	output logic              shared_power_switching,
	output logic              one_translator_mode,
	output logic              suppress_frame_end_eop
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// number of set bits in a port nibble
	function automatic logic [2:0] ones4(input logic [3:0] v);
		ones4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
	endfunction : ones4

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	hcl_state_e  state_reg,  state_next;
	hcl_load_e   load_reg,   load_next;
	logic [7:0]  img_reg  [IMG_BYTES];
	logic [7:0]  img_next [IMG_BYTES];
	logic [3:0]  div_reg,    div_next;
	logic        sck_reg,    sck_next;
	logic        cs_b_reg,   cs_b_next;
	logic [23:0] tx_reg,     tx_next;
	logic [7:0]  rx_reg,     rx_next;
	logic [4:0]  bit_reg,    bit_next;
	logic [3:0]  idx_reg,    idx_next;
	logic [3:0]  last_reg,   last_next;
	logic        valid_reg,  valid_next;
	logic [31:0] rdata_reg,  rdata_next;
	logic        miso_s1_reg, miso_s2_reg, miso_s3_reg, miso_f_reg;
	logic        miso_f_next;
	logic        half_done;
	logic        rise;
	logic        fall;
	logic [7:0]  byte_in;
	logic [7:0]  opt;

	// ---------------------------------------------------------------
	// data input synchroniser
	// ---------------------------------------------------------------
	// filtered level moves only when the two later stages agree
	always_comb begin
		miso_f_next = (miso_s2_reg == miso_s3_reg) ? miso_s3_reg : miso_f_reg;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			miso_s1_reg <= 1'b0;
			miso_s2_reg <= 1'b0;
			miso_s3_reg <= 1'b0;
			miso_f_reg  <= 1'b0;
		end else begin
			miso_s1_reg <= mem_miso;
			miso_s2_reg <= miso_s1_reg;
			miso_s3_reg <= miso_s2_reg;
			miso_f_reg  <= miso_f_next;
		end
	end

	// ---------------------------------------------------------------
	// load sequencer and serial shifter
	// ---------------------------------------------------------------
	assign half_done = (div_reg == SCK_HALF_LAST);
	assign rise      = half_done && !sck_reg;
	assign fall      = half_done && sck_reg;
	assign byte_in   = {rx_reg[6:0], miso_f_reg};

	// clock idles low; memory samples on rise, we sample on rise too
	always_comb begin
		state_next = state_reg;
		load_next  = load_reg;
		img_next   = img_reg;
		div_next   = (state_reg == HCL_ST_DONE) ? '0 : div_reg + 4'h1;
		sck_next   = sck_reg;
		cs_b_next  = cs_b_reg;
		tx_next    = tx_reg;
		rx_next    = rx_reg;
		bit_next   = bit_reg;
		idx_next   = idx_reg;
		last_next  = last_reg;
		valid_next = valid_reg;
		if (half_done) begin
			div_next = '0;
		end
		case (state_reg)
			HCL_ST_START: begin
				cs_b_next = 1'b0;
				tx_next   = {CMD_READ, START_ADDR};
				bit_next  = '0;
				if (half_done) begin
					state_next = HCL_ST_CMD;
				end
			end
			HCL_ST_CMD: begin
				if (half_done) begin
					sck_next = !sck_reg;
				end
				if (fall) begin
					if (bit_reg == CMD_LAST_BIT) begin
						state_next = HCL_ST_DATA;
						bit_next   = '0;
						idx_next   = '0;
					end else begin
						tx_next  = {tx_reg[22:0], 1'b0};
						bit_next = bit_reg + 5'h1;
					end
				end
			end
			HCL_ST_DATA: begin
				if (half_done) begin
					sck_next = !sck_reg;
				end
				if (rise) begin
					rx_next = byte_in;
				end
				if (fall) begin
					bit_next = bit_reg + 5'h1;
					if (bit_reg[2:0] == BYTE_LAST_BIT) begin
						bit_next          = '0;
						img_next[idx_reg] = rx_reg;
						idx_next          = idx_reg + 4'h1;
						if (idx_reg == '0) begin
							if (rx_reg == SIG_DEFAULT) begin
								load_next = HCL_LOAD_DEFAULT;
								last_next = LAST_DEFAULT;
							end else if (rx_reg == SIG_CONFIG) begin
								load_next = HCL_LOAD_CONFIG;
								last_next = LAST_CONFIG;
							end else begin
								state_next = HCL_ST_DONE;
							end
						end else if (idx_reg == last_reg) begin
							state_next = HCL_ST_DONE;
						end
						if (state_next == HCL_ST_DONE) begin
							cs_b_next  = 1'b1;
							valid_next = 1'b1;
						end
					end
				end
			end
			HCL_ST_DONE: begin
				sck_next  = 1'b0;
				cs_b_next = 1'b1;
			end
			default: begin
				state_next = HCL_ST_DONE;
			end
		endcase
		// software reload restarts from the defaults
		if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_RELOAD]) begin
			state_next = HCL_ST_START;
			load_next  = HCL_LOAD_NONE;
			valid_next = 1'b0;
			sck_next   = 1'b0;
			cs_b_next  = 1'b1;
			div_next   = '0;
			img_next   = '{default: 8'h00};
			img_next[B_VID_LO]       = DEF_VENDOR_ID[7:0];
			img_next[B_VID_LO + 1]   = DEF_VENDOR_ID[15:8];
			img_next[B_PID_LO]       = DEF_PRODUCT_ID[7:0];
			img_next[B_PID_LO + 1]   = DEF_PRODUCT_ID[15:8];
			img_next[B_DID_LO]       = DEF_RELEASE_ID[7:0];
			img_next[B_DID_LO + 1]   = DEF_RELEASE_ID[15:8];
			img_next[B_OC_FILTER]    = DEF_OC_FILTER;
			img_next[B_PORTS]        = DEF_PORTS;
			img_next[B_MAX_POWER]    = DEF_MAX_POWER;
			img_next[B_CTRL_CURRENT] = DEF_CTRL_CURRENT;
			img_next[B_POWER_ON]     = DEF_POWER_ON;
			img_next[B_OPTIONS]      = DEF_OPTIONS;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= HCL_ST_START;
			load_reg  <= HCL_LOAD_NONE;
			img_reg   <= '{8'h00, DEF_VENDOR_ID[7:0], DEF_VENDOR_ID[15:8],
			               DEF_PRODUCT_ID[7:0], DEF_PRODUCT_ID[15:8],
			               DEF_RELEASE_ID[7:0], DEF_RELEASE_ID[15:8],
			               DEF_OC_FILTER, DEF_PORTS, DEF_MAX_POWER,
			               DEF_CTRL_CURRENT, DEF_POWER_ON, DEF_OPTIONS};
			div_reg   <= '0;
			sck_reg   <= 1'b0;
			cs_b_reg  <= 1'b1;
			tx_reg    <= '0;
			rx_reg    <= '0;
			bit_reg   <= '0;
			idx_reg   <= '0;
			last_reg  <= '0;
			valid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			load_reg  <= load_next;
			img_reg   <= img_next;
			div_reg   <= div_next;
			sck_reg   <= sck_next;
			cs_b_reg  <= cs_b_next;
			tx_reg    <= tx_next;
			rx_reg    <= rx_next;
			bit_reg   <= bit_next;
			idx_reg   <= idx_next;
			last_reg  <= last_next;
			valid_reg <= valid_next;
		end
	end

	// ---------------------------------------------------------------
	// pins and configuration fields
	// ---------------------------------------------------------------
	assign mem_sck  = sck_reg;
	assign mem_cs_b = cs_b_reg;
	assign mem_mosi = tx_reg[23];
	assign opt      = img_reg[B_OPTIONS];

	// identifiers assembled low byte from the lower address
	assign vendor_id                  = {img_reg[B_VID_LO + 1], img_reg[B_VID_LO]};
	assign product_id                 = {img_reg[B_PID_LO + 1], img_reg[B_PID_LO]};
	assign device_release_id          = {img_reg[B_DID_LO + 1], img_reg[B_DID_LO]};
	assign enabled_port_oc_filter_ms  = img_reg[B_OC_FILTER][7:4];
	assign disabled_port_oc_filter_ms = img_reg[B_OC_FILTER][3:0];
	assign usable_port_mask           = img_reg[B_PORTS][7:4];
	assign port_count                 = ones4(img_reg[B_PORTS][7:4]);
	assign detachable_port_mask       = img_reg[B_PORTS][3:0];
	assign upstream_current_budget    = img_reg[B_MAX_POWER];
	assign controller_current_need    = img_reg[B_CTRL_CURRENT];
	assign port_power_settle_time     = img_reg[B_POWER_ON];
	assign port_power_ctrl_mask       = PWR_CTRL_MASK;
	assign config_valid               = valid_reg;

	// option bits; bit 6 and reserved bit 3 drive nothing
	assign accept_zero_desc_type  = opt[OPT_ZERO_TYPE];
	assign limit_to_12mbit        = opt[OPT_FS_ONLY];
	assign indicator_leds_off     = opt[OPT_NO_LEDS];
	assign shared_power_switching = opt[OPT_GANGED];
	assign one_translator_mode    = opt[OPT_SINGLE_TT];
	assign suppress_frame_end_eop = opt[OPT_NO_EOP];

	// hub characteristics: switching b1:b0, overcurrent b4:b3, leds b7
	always_comb begin
		hub_characteristics    = '0;
		hub_characteristics[0] = !opt[OPT_GANGED];
		hub_characteristics[3] = !opt[OPT_GANGED];
		hub_characteristics[7] = !opt[OPT_NO_LEDS];
	end

	// type zero is stalled unless the option allows it
	always_comb begin
		hub_desc_stall = 1'b0;
		if (hub_desc_type == ZERO_DESC_TYPE) begin
			hub_desc_stall = !opt[OPT_ZERO_TYPE];
		end else if (hub_desc_type != HUB_DESC_TYPE) begin
			hub_desc_stall = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// register port read data
	// ---------------------------------------------------------------
	always_comb begin
		rdata_next = '0;
		if (reg_rd) begin
			case (reg_addr)
				REG_STATUS:  rdata_next = {28'h0, load_reg, state_reg == HCL_ST_DONE,
				                           valid_reg};
				REG_IDS:     rdata_next = {product_id, vendor_id};
				REG_RELEASE: rdata_next = {16'h0, device_release_id};
				REG_CONFIG:  rdata_next = {img_reg[B_OPTIONS], img_reg[B_POWER_ON],
				                           img_reg[B_PORTS], img_reg[B_OC_FILTER]};
				default:     rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

endmodule : hcl_loader

/* hcl_loader_chk.sv */
// assertions on the loader's ports
`timescale 1ns/1ns

module hcl_loader_chk (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// memory pins
	input wire logic        mem_sck,
	input wire logic        mem_cs_b,
	input wire logic        mem_mosi,
	// descriptor outputs
	input wire logic [7:0]  hub_desc_type,
	input wire logic        hub_desc_stall,
	input wire logic        config_valid,
	input wire logic [15:0] vendor_id,
	input wire logic [3:0]  usable_port_mask,
	input wire logic [2:0]  port_count,
	input wire logic [15:0] hub_characteristics,
	input wire logic [7:0]  port_power_ctrl_mask,
	input wire logic        accept_zero_desc_type,
	input wire logic        indicator_leds_off,
	input wire logic        shared_power_switching
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// descriptor type screening
	a_zero_type_stall: assert property (
		hub_desc_type == 8'h00 |-> hub_desc_stall == !accept_zero_desc_type)
		else $error("zero type stall wrong");
	a_hub_type_pass: assert property (
		hub_desc_type == 8'h29 |-> !hub_desc_stall) else $error("hub type stalled");
	// descriptor fields derived from the image, and the fixed power mask
	a_port_count: assert property (
		port_count == $countones(usable_port_mask)) else $error("port count wrong");
	a_leds_char: assert property (
		hub_characteristics[7] == !indicator_leds_off) else $error("indicator bit wrong");
	a_gang_char: assert property (
		hub_characteristics[4:0] == {1'b0, !shared_power_switching, 2'b00,
		!shared_power_switching}) else $error("power mode bits wrong");
	a_power_mask: assert property (
		port_power_ctrl_mask == 8'hff) else $error("power mask wrong");
	// load completion and hold
	a_valid_end: assert property (
		$rose(config_valid) |-> $rose(mem_cs_b)) else $error("valid not at frame end");
	a_ids_hold: assert property (
		config_valid && $past(config_valid) |-> $stable(vendor_id))
		else $error("id changed while valid");
	// serial clock shape
	a_sck_high: assert property (
		$rose(mem_sck) |-> mem_sck [*8] ##1 !mem_sck) else $error("sck high time wrong");
	a_mosi_steady: assert property (
		$rose(mem_sck) |-> $stable(mem_mosi)) else $error("mosi moved at rise");
	a_sck_idle: assert property (
		mem_cs_b |-> !mem_sck) else $error("sck active while deselected");
endmodule : hcl_loader_chk

bind hcl_loader hcl_loader_chk u_hcl_loader_chk (.clk, .rst_b, .mem_sck, .mem_cs_b,
	.mem_mosi, .hub_desc_type, .hub_desc_stall, .config_valid, .vendor_id,
	.usable_port_mask, .port_count, .hub_characteristics, .port_power_ctrl_mask,
	.accept_zero_desc_type, .indicator_leds_off, .shared_power_switching);

/* hcl_mem_model.sv */
// serial memory model holding the configuration image
`timescale 1ns/1ns

module hcl_mem_model (
	// memory pins
	input  wire logic         mem_sck,
	input  wire logic         mem_cs_b,
	input  wire logic         mem_mosi,
	output logic              mem_miso,
	// image contents, byte k in bits 8k+7..8k
	input  wire logic [103:0] img
);
	int          n_bit;
	int          k;
	logic [23:0] cmd;

	// line released outside data: toggle so no stale level is seen
	initial begin
		mem_miso = 1'b0;
		n_bit = 0;
		forever #7 if (mem_cs_b || n_bit < 24) mem_miso = ~mem_miso;
	end

	// frame start clears the rise count
	always @(negedge mem_cs_b) n_bit = 0;

	// collect command byte and two address bytes, msb first
	always @(posedge mem_sck) begin
		if (!mem_cs_b) begin
			if (n_bit < 24)
				cmd = {cmd[22:0], mem_mosi};
			n_bit = n_bit + 1;
		end
	end

	// drive data after each fall; a wrong command gets garbage back
	always @(negedge mem_sck) begin
		if (!mem_cs_b && n_bit >= 24) begin
			k = (n_bit - 24) / 8 + int'(cmd[15:0]);
			if (cmd[23:16] !== 8'h03 || k > 12)
				mem_miso = ~mem_miso;
			else
				mem_miso = img[8 * k + 7 - (n_bit - 24) % 8];
		end
	end
endmodule : hcl_mem_model

/* hcl_pkg.sv */
// constants shared by the hub configuration loader
package hcl_pkg;

	// ---------------------------------------------------------------
	// memory image layout
	// ---------------------------------------------------------------
	localparam logic [7:0]  SIG_DEFAULT      = 8'hd0;
	localparam logic [7:0]  SIG_CONFIG       = 8'hd2;
	localparam logic [3:0]  IMG_BYTES        = 4'hd;
	localparam logic [3:0]  LAST_DEFAULT     = 4'h6;
	localparam logic [3:0]  LAST_CONFIG      = 4'hc;
	localparam int          B_VID_LO         = 1;
	localparam int          B_PID_LO         = 3;
	localparam int          B_DID_LO         = 5;
	localparam int          B_OC_FILTER      = 7;
	localparam int          B_PORTS          = 8;
	localparam int          B_MAX_POWER      = 9;
	localparam int          B_CTRL_CURRENT   = 10;
	localparam int          B_POWER_ON       = 11;
	localparam int          B_OPTIONS        = 12;

	// option bits of the last image byte (bit 6 unused, bit 3 reserved)
	localparam int          OPT_ZERO_TYPE    = 7;
	localparam int          OPT_FS_ONLY      = 5;
	localparam int          OPT_NO_LEDS      = 4;
	localparam int          OPT_GANGED       = 2;
	localparam int          OPT_SINGLE_TT    = 1;
	localparam int          OPT_NO_EOP       = 0;

	// ---------------------------------------------------------------
	// reset values of the configured fields, fixed power mask and descriptor types
	// ---------------------------------------------------------------
	localparam logic [7:0]  DEF_OC_FILTER    = 8'h88;
	localparam logic [7:0]  DEF_PORTS        = 8'hff;
	localparam logic [7:0]  DEF_MAX_POWER    = 8'h32;
	localparam logic [7:0]  DEF_CTRL_CURRENT = 8'h64;
	localparam logic [7:0]  DEF_POWER_ON     = 8'h32;
	localparam logic [7:0]  DEF_OPTIONS      = 8'h00;
	localparam logic [7:0]  PWR_CTRL_MASK    = 8'hff;
	localparam logic [7:0]  HUB_DESC_TYPE    = 8'h29;
	localparam logic [7:0]  ZERO_DESC_TYPE   = 8'h00;

	// ---------------------------------------------------------------
	// serial memory read command and link timing
	// ---------------------------------------------------------------
	localparam logic [7:0]  CMD_READ         = 8'h03;
	localparam logic [15:0] START_ADDR       = 16'h0000;
	localparam logic [4:0]  CMD_LAST_BIT     = 5'h17;
	localparam logic [2:0]  BYTE_LAST_BIT    = 3'h7;
	localparam int          CLK_PERIOD_NS    = 10;
	localparam int          SCK_HALF_NS      = 80;
	localparam int          SCK_HALF_CYC     = SCK_HALF_NS / CLK_PERIOD_NS;
	localparam logic [3:0]  SCK_HALF_LAST    = 4'(SCK_HALF_CYC - 1);

	// ---------------------------------------------------------------
	// register port map
	// ---------------------------------------------------------------
	localparam logic [3:0]  REG_CTRL         = 4'h0;
	localparam logic [3:0]  REG_STATUS       = 4'h1;
	localparam logic [3:0]  REG_IDS          = 4'h2;
	localparam logic [3:0]  REG_RELEASE      = 4'h3;
	localparam logic [3:0]  REG_CONFIG       = 4'h4;
	localparam int          CTRL_RELOAD      = 0;

	typedef enum logic [1:0] {
		HCL_LOAD_NONE,
		HCL_LOAD_DEFAULT,
		HCL_LOAD_CONFIG
	} hcl_load_e;

	typedef enum logic [2:0] {
		HCL_ST_START,
		HCL_ST_CMD,
		HCL_ST_DATA,
		HCL_ST_DONE
	} hcl_state_e;

endpackage : hcl_pkg

/* tb_hcl_loader.sv */
// self-checking bench for the hub configuration loader
`timescale 1ns/1ns

module tb_hcl_loader
	import hcl_pkg::*;
;
	logic         clk, rst_b, reg_wr, reg_rd, sck, cs_b, mosi, miso, stall, valid;
	logic [3:0]   reg_addr, oc_en, oc_dis, usable, detach;
	logic [31:0]  reg_wdata, reg_rdata;
	logic [7:0]   desc_type, budget, ctrl_cur, settle, pp_mask;
	logic [15:0]  vid, pid, rel, hub_char;
	logic [2:0]   count;
	logic         acc0, fs, leds, gang, one_tt, no_eop, rd_seen, valid_d;
	logic [103:0] img;
	logic [127:0] exp_cfg[$];
	logic [31:0]  exp_rd[$];
	logic [7:0]   b[0:12];
	logic [127:0] exp_now;
	int           bad_count, n_tests;
	wire  [127:0] obs = {13'h0, vid, pid, rel, oc_en, oc_dis, usable, detach, budget,
		ctrl_cur, settle, acc0, 1'b0, fs, leds, 1'b0, gang, one_tt, no_eop, hub_char, count};

	hcl_loader u_hcl_loader (.clk(clk), .rst_b(rst_b), .mem_sck(sck), .mem_cs_b(cs_b),
		.mem_mosi(mosi), .mem_miso(miso), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hub_desc_type(desc_type),
		.hub_desc_stall(stall), .config_valid(valid), .vendor_id(vid), .product_id(pid),
		.device_release_id(rel), .enabled_port_oc_filter_ms(oc_en),
		.disabled_port_oc_filter_ms(oc_dis), .usable_port_mask(usable), .port_count(count),
		.detachable_port_mask(detach), .upstream_current_budget(budget),
		.controller_current_need(ctrl_cur), .port_power_settle_time(settle),
		.hub_characteristics(hub_char), .port_power_ctrl_mask(pp_mask),
		.accept_zero_desc_type(acc0), .limit_to_12mbit(fs), .indicator_leds_off(leds),
		.shared_power_switching(gang), .one_translator_mode(one_tt),
		.suppress_frame_end_eop(no_eop));

	hcl_mem_model u_hcl_mem_model (.mem_sck(sck), .mem_cs_b(cs_b), .mem_mosi(mosi),
		.mem_miso(miso), .img(img));

	// clock and reset
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
	end

	task automatic check(input logic [127:0] seen, input logic [127:0] want);
		n_tests++;
		if (seen !== want) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	// watcher: compare read data and each finished load against the oldest note
	always @(posedge clk) begin
		if (rd_seen)
			check(reg_rdata, exp_rd.pop_front());
		if (valid === 1'b1 && valid_d !== 1'b1) begin
			exp_now = exp_cfg.pop_front();
			check(obs[127:67], exp_now[127:67]);
			check(obs[66:27], exp_now[66:27]);
			check(obs[26:0], exp_now[26:0]);
		end
		rd_seen = reg_rd;
		valid_d = valid;
	end

	task automatic rd(input logic [3:0] a, input logic [31:0] w);
		@(posedge clk);
		exp_rd.push_back(w);
		reg_addr <= a;
		reg_rd <= 1'b1;
	endtask : rd

	// program an image, restart the load when reload is set, then check descriptors and registers
	task automatic load(input logic [7:0] sig, input bit reload);
		logic [1:0]  ty;
		logic [47:0] v;
		logic [47:0] c;
		b[0] = sig;
		for (int i = 1; i < 13; i++) b[i] = 8'($urandom);
		b[12][3] = 1'b0;
		for (int i = 0; i < 13; i++) img[8 * i +: 8] = b[i];
		ty = (sig == SIG_CONFIG) ? 2'd2 : (sig == SIG_DEFAULT) ? 2'd1 : 2'd0;
		v = (ty == 2'd0) ? {16'h0001, 16'h0002, 16'h0003} :
			{b[2], b[1], b[4], b[3], b[6], b[5]};
		c = (ty == 2'd2) ? {b[7], b[8], b[9], b[10], b[11], b[12]} : {DEF_OC_FILTER,
			DEF_PORTS, DEF_MAX_POWER, DEF_CTRL_CURRENT, DEF_POWER_ON, DEF_OPTIONS};
		exp_cfg.push_back({13'h0, v, c[47:8], c[7:0] & 8'hb7, 8'h00, ~c[4], 3'b000,
			~c[2], 2'b00, ~c[2], 3'($countones(c[39:36]))});
		if (reload) begin
			@(posedge clk);
			reg_addr <= REG_CTRL;
			reg_wdata <= 32'h1;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
			repeat (3) @(posedge clk);
		end
		for (int i = 0; i < 3000 && valid !== 1'b1; i++) @(posedge clk);
		check(valid, 1'b1);
		desc_type <= ZERO_DESC_TYPE;
		@(posedge clk);
		check(stall, !c[7]);
		desc_type <= HUB_DESC_TYPE;
		@(posedge clk);
		check(stall, 1'b0);
		rd(REG_STATUS, {28'h0, ty, 2'b11});
		rd(REG_IDS, {v[31:16], v[47:32]});
		rd(REG_RELEASE, {16'h0, v[15:0]});
		rd(REG_CONFIG, {c[7:0], c[15:8], c[39:32], c[47:40]});
		rd(4'hf, 32'h0);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : load

	// main sequence: configured, default, bad signature, then random images
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, rd_seen, valid_d} = '0;
		desc_type = HUB_DESC_TYPE;
		bad_count = 0;
		n_tests = 0;
		void'($urandom(32'h62b9));
		load(SIG_CONFIG, 1'b0);
		load(SIG_DEFAULT, 1'b1);
		load(8'h5a, 1'b1);
		repeat (3) load(SIG_CONFIG, 1'b1);
		repeat (4) @(posedge clk);
		check(exp_cfg.size() + exp_rd.size(), 0);
		wrap_up();
	end

	// watchdog against a hung load
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		wrap_up();
	end
endmodule : tb_hcl_loader
